// >>> verilog/gpio_regs.svh
`ifndef GPIO_REGS_SVH
`define GPIO_REGS_SVH
// Register indices; the APB byte address is four times the index
`define IDX_FIRST_PORT 8'h06
`define IDX_OPTION 8'h81
`define IDX_FIRST_DIR 8'h86
`define IDX_THIRD_CTRL 8'h89
`define IDX_SECOND_PORT 8'h07
`define IDX_SECOND_DIR 8'h87
`define IDX_THIRD_PORT 8'h09
`define IDX_CHANGE_FLAGS 8'h0b
`define IDX_SLAVE_DATA 8'h08
// Field positions
`define OPT_PULLUP_DISABLE_N 7
`define OPT_EXT_EDGE 6
`define CTRL_IBF 7
`define CTRL_OBF 6
`define CTRL_INPUT_OVERFLOW 5
`define CTRL_SLAVE_SEL 4
// Reset values
`define RST_OPTION 8'hff
`define RST_FIRST_DIR 8'hff
`define RST_THIRD_DIR 3'h7
`define RST_BYTE 8'h00
`define RST_WORD 32'h0000_0000
`endif

// >>> verilog/gpio_pkg.sv
package gpio_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [2:0] trio_t;
  typedef enum logic [1:0] {
    ph_idle = 2'b00,
    ph_access = 2'b01
  } apb_phase_t;
endpackage

// >>> verilog/multi_port_gpio.sv
`timescale 1ns/1ps
`include "gpio_regs.svh"
module multi_port_gpio
  import gpio_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire gpio_pkg::byte_t first_port_in,
  output gpio_pkg::byte_t first_port_out,
  output gpio_pkg::byte_t first_port_oe,
  output gpio_pkg::byte_t first_port_pullup,
  output gpio_pkg::byte_t first_port_schmitt,
  input wire logic prog_mode,
  output logic ext_interrupt_edge,
  output logic change_flag,
  output logic prog_clock_pin,
  output logic prog_data_pin,
  input wire gpio_pkg::byte_t second_port_in,
  output gpio_pkg::byte_t second_port_out,
  output gpio_pkg::byte_t second_port_oe,
  input wire gpio_pkg::byte_t periph_select,
  input wire gpio_pkg::byte_t periph_force_out,
  input wire gpio_pkg::byte_t periph_out,
  output gpio_pkg::byte_t periph_in,
  input wire gpio_pkg::trio_t third_port_in,
  output gpio_pkg::trio_t third_port_out,
  output gpio_pkg::trio_t third_port_oe,
  output logic third_port_schmitt,
  input wire gpio_pkg::byte_t slave_bus_in,
  output gpio_pkg::byte_t slave_bus_out,
  output logic slave_bus_oe
);
  import gpio_pkg::*;

  byte_t first_latch_q;
  byte_t first_dir_q;
  byte_t option_q;
  byte_t second_latch_q;
  byte_t second_dir_q;
  trio_t third_latch_q;
  trio_t third_dir_q;
  logic slave_sel_q;
  logic ibf_q;
  logic obf_q;
  logic input_overflow_q;
  byte_t slave_in_q;
  byte_t slave_out_q;
  logic [3:0] change_last_q;
  logic change_q;
  logic [2:0] ctl_prev_q;
  apb_phase_t phase_q;

  logic wr_en;
  logic rd_en;
  logic [7:0] addr8;
  logic hit;
  logic [31:0] rdata_d;
  byte_t wbyte;
  byte_t third_ctrl_rd;
  logic [3:0] change_in;
  logic [3:0] change_mask;
  logic cs_act;
  logic wr_act;
  logic rd_act;
  logic slave_wr_end;
  logic slave_rd_end;
  byte_t second_oe_d;

  // APB decode, word aligned index, no wait states
  assign addr8 = paddr[9:2];
  assign wbyte = pwdata[7:0];
  assign wr_en = clk_en && psel && penable && pwrite && pstrb[0]
    && (phase_q == ph_access);
  assign rd_en = clk_en && psel && penable && !pwrite
    && (phase_q == ph_access);
  assign hit = (paddr[31:10] == 22'h0) && (paddr[1:0] == 2'h0) && (
    addr8 == `IDX_FIRST_PORT || addr8 == `IDX_OPTION ||
    addr8 == `IDX_FIRST_DIR || addr8 == `IDX_THIRD_CTRL ||
    addr8 == `IDX_SECOND_PORT || addr8 == `IDX_SECOND_DIR ||
    addr8 == `IDX_THIRD_PORT || addr8 == `IDX_CHANGE_FLAGS ||
    addr8 == `IDX_SLAVE_DATA);

  // Control register readback; bit 3 always zero
  assign third_ctrl_rd = {ibf_q, obf_q, input_overflow_q, slave_sel_q, 1'b0,
    third_dir_q};

  // Change detection on input pins 4 to 7
  assign change_in = first_port_in[7:4];
  assign change_mask = first_dir_q[7:4];
  // Slave port strobes, active low, sampled synchronously
  assign cs_act = slave_sel_q && !third_port_in[2];
  assign wr_act = cs_act && !third_port_in[1];
  assign rd_act = cs_act && !third_port_in[0];
  assign slave_wr_end = slave_sel_q && ctl_prev_q[1] && !(wr_act);
  assign slave_rd_end = slave_sel_q && ctl_prev_q[0] && !(rd_act);

  // Read mux
  always_comb begin
    rdata_d = `RST_WORD;
    case (addr8)
      `IDX_FIRST_PORT: rdata_d[7:0] = first_port_in;
      `IDX_OPTION: rdata_d[7:0] = option_q;
      `IDX_FIRST_DIR: rdata_d[7:0] = first_dir_q;
      `IDX_THIRD_CTRL: rdata_d[7:0] = third_ctrl_rd;
      `IDX_SECOND_PORT: rdata_d[7:0] = second_port_in;
      `IDX_SECOND_DIR: rdata_d[7:0] = second_dir_q;
      `IDX_THIRD_PORT: rdata_d[2:0] = third_port_in;
      `IDX_CHANGE_FLAGS: rdata_d[0] = change_q;
      `IDX_SLAVE_DATA: rdata_d[7:0] = slave_in_q;
      default: rdata_d = `RST_WORD;
    endcase
  end

  // APB phase tracker
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= ph_idle;
    end else if (clk_en) begin
      case (phase_q)
        ph_idle: phase_q <= (psel && !penable) ? ph_access : ph_idle;
        ph_access: phase_q <= ph_idle;
        default: phase_q <= ph_idle;
      endcase
    end
  end

  // APB answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `RST_WORD;
    end else if (clk_en) begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      prdata <= (psel && !penable && !pwrite) ? rdata_d : `RST_WORD;
    end
  end

  // First port data latch: not reset, survives all resets
  always_ff @(posedge pclk) begin
    if (wr_en && hit && addr8 == `IDX_FIRST_PORT) begin
      first_latch_q <= wbyte;
    end
  end

  // Direction and option registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_dir_q <= `RST_FIRST_DIR;
      option_q <= `RST_OPTION;
      second_dir_q <= `RST_FIRST_DIR;
    end else if (wr_en && hit) begin
      if (addr8 == `IDX_FIRST_DIR) first_dir_q <= wbyte;
      if (addr8 == `IDX_OPTION) option_q <= wbyte;
      if (addr8 == `IDX_SECOND_DIR) second_dir_q <= wbyte;
    end
  end

  // Second and third data latches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      second_latch_q <= `RST_BYTE;
      third_latch_q <= 3'h0;
    end else if (wr_en && hit) begin
      if (addr8 == `IDX_SECOND_PORT) second_latch_q <= wbyte;
      if (addr8 == `IDX_THIRD_PORT) third_latch_q <= wbyte[2:0];
    end
  end

  // Third port control: direction and slave port select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      third_dir_q <= `RST_THIRD_DIR;
      slave_sel_q <= 1'b0;
    end else if (wr_en && hit && addr8 == `IDX_THIRD_CTRL) begin
      third_dir_q <= wbyte[2:0];
      slave_sel_q <= wbyte[`CTRL_SLAVE_SEL];
    end
  end

  // Slave port strobe history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_prev_q <= 3'h0;
    end else if (clk_en) begin
      ctl_prev_q <= {cs_act, wr_act, rd_act};
    end
  end

  // Input buffer: word captured at end of external write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slave_in_q <= `RST_BYTE;
      ibf_q <= 1'b0;
    end else if (clk_en) begin
      if (slave_wr_end) begin
        slave_in_q <= slave_bus_in;
        ibf_q <= 1'b1;
      end else if (rd_en && hit && addr8 == `IDX_SLAVE_DATA) begin
        ibf_q <= 1'b0;
      end
    end
  end

  // Overflow flag: set wins over software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_overflow_q <= 1'b0;
    end else if (clk_en) begin
      if (slave_wr_end && ibf_q) begin
        input_overflow_q <= 1'b1;
      end else if (wr_en && hit && addr8 == `IDX_THIRD_CTRL &&
                   !wbyte[`CTRL_INPUT_OVERFLOW]) begin
        input_overflow_q <= 1'b0;
      end
    end
  end

  // Output buffer: CPU write fills, external read empties
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slave_out_q <= `RST_BYTE;
      obf_q <= 1'b0;
    end else if (clk_en) begin
      if (wr_en && hit && addr8 == `IDX_SLAVE_DATA) begin
        slave_out_q <= wbyte;
        obf_q <= 1'b1;
      end else if (slave_rd_end) begin
        obf_q <= 1'b0;
      end
    end
  end

  // Interrupt-on-change: latch on first-port read, flag sticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      change_last_q <= 4'h0;
      change_q <= 1'b0;
    end else if (clk_en) begin
      if (rd_en && hit && addr8 == `IDX_FIRST_PORT) begin
        change_last_q <= change_in;
      end
      if (|((change_in ^ change_last_q) & change_mask)) begin
        change_q <= 1'b1;
      end else if (wr_en && hit && addr8 == `IDX_CHANGE_FLAGS &&
                   wbyte[0]) begin
        change_q <= 1'b0;
      end
    end
  end

  // Second port: peripheral direction override gated by select
  always_comb begin
    second_oe_d = ~second_dir_q;
    for (int i = 0; i < 8; i++) begin
      if (periph_select[i]) begin
        second_oe_d[i] = periph_force_out[i];
      end
    end
  end

  // Pin drivers, all registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_port_out <= `RST_BYTE;
      first_port_oe <= `RST_BYTE;
      first_port_pullup <= `RST_BYTE;
      first_port_schmitt <= `RST_BYTE;
      ext_interrupt_edge <= 1'b1;
      change_flag <= 1'b0;
      prog_clock_pin <= 1'b0;
      prog_data_pin <= 1'b0;
      second_port_out <= `RST_BYTE;
      second_port_oe <= `RST_BYTE;
      periph_in <= `RST_BYTE;
      third_port_out <= 3'h0;
      third_port_oe <= 3'h0;
      third_port_schmitt <= 1'b1;
      slave_bus_out <= `RST_BYTE;
      slave_bus_oe <= 1'b0;
    end else if (clk_en) begin
      first_port_out <= first_latch_q;
      first_port_oe <= ~first_dir_q;
      first_port_pullup <= option_q[`OPT_PULLUP_DISABLE_N] ?
        `RST_BYTE : first_dir_q;
      first_port_schmitt <= {prog_mode, prog_mode, 5'h00,
        ext_interrupt_edge_use()};
      ext_interrupt_edge <= option_q[`OPT_EXT_EDGE];
      change_flag <= change_q;
      prog_clock_pin <= first_port_in[6];
      prog_data_pin <= first_port_in[7];
      for (int i = 0; i < 8; i++) begin
        second_port_out[i] <= periph_select[i] ? periph_out[i]
          : second_latch_q[i];
      end
      second_port_oe <= second_oe_d;
      periph_in <= second_port_in;
      third_port_out <= third_latch_q;
      third_port_oe <= slave_sel_q ? 3'h0 : ~third_dir_q;
      third_port_schmitt <= !slave_sel_q;
      slave_bus_out <= slave_out_q;
      slave_bus_oe <= rd_act;
    end
  end

  // Bit 0 runs as interrupt input while it is configured as input
  function automatic logic ext_interrupt_edge_use();
    return first_dir_q[0];
  endfunction
endmodule

// >>> tb/multi_port_gpio_chk.sv
`timescale 1ns/1ps
module gpio_port_chk
  import gpio_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  input wire logic prog_mode,
  input wire logic prog_clock_pin,
  input wire logic prog_data_pin,
  input wire gpio_pkg::byte_t first_port_in,
  input wire gpio_pkg::byte_t first_port_oe,
  input wire gpio_pkg::byte_t first_port_pullup,
  input wire gpio_pkg::byte_t first_port_schmitt,
  input wire gpio_pkg::byte_t second_port_oe,
  input wire gpio_pkg::byte_t periph_select,
  input wire gpio_pkg::byte_t periph_force_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Bus answer shape
  a_ready_after_setup:
    assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle:
    assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_zero_data:
    assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("bad error answer");
  // Pin configuration outputs, one edge behind their cause
  a_pullup_on_input:
    assert property ((first_port_pullup & first_port_oe) == 8'h00)
    else $error("pull-up on driven pin");
  a_schmitt_ext_int:
    assert property ($past(presetn) |->
      first_port_schmitt[0] == !first_port_oe[0])
    else $error("bit0 buffer type wrong");
  a_schmitt_prog_mode:
    assert property ($past(presetn) |->
      first_port_schmitt[7:6] == {2{$past(prog_mode)}})
    else $error("programming buffer type wrong");
  a_prog_pin_copy:
    assert property ($past(presetn) |->
      {prog_data_pin, prog_clock_pin} == $past(first_port_in[7:6]))
    else $error("programming pins not copied");
  a_periph_override:
    assert property ($past(presetn) |-> ((second_port_oe ^
      $past(periph_force_out)) & $past(periph_select)) == 8'h00)
    else $error("peripheral override ignored");
  cover property (pready && pslverr);
  cover property (first_port_pullup != 8'h00);
  cover property (prog_mode && first_port_schmitt[7]);
endmodule

// >>> tb/pin_model.sv
`timescale 1ns/1ps
module pin_model
  import gpio_pkg::*;
(
  input wire logic pclk,
  input wire gpio_pkg::byte_t first_port_out,
  input wire gpio_pkg::byte_t first_port_oe,
  input wire gpio_pkg::byte_t first_port_pullup,
  output gpio_pkg::byte_t first_port_in,
  output gpio_pkg::trio_t third_port_in,
  output gpio_pkg::byte_t slave_bus_in,
  input wire gpio_pkg::byte_t slave_bus_out,
  input wire logic slave_bus_oe
);
  byte_t ext_val = 8'h00;
  byte_t ext_en = 8'h00;
  byte_t last_q = 8'h00;
  // Device drive, then outside drive, then pull-up, else drift
  assign first_port_in = (first_port_oe & first_port_out) |
    (~first_port_oe & ext_en & ext_val) |
    (~first_port_oe & ~ext_en & (first_port_pullup | ~last_q));
  always_ff @(posedge pclk) last_q <= first_port_in;
  initial begin
    third_port_in = 3'h7;
    slave_bus_in = 8'h00;
  end
  // Outside drivers on the first port
  task drive(input byte_t v, input byte_t en);
    ext_val <= v;
    ext_en <= en;
  endtask
  // Strobed write; data held past the rising strobe
  task ext_wr(input byte_t v);
    @(posedge pclk);
    third_port_in <= 3'b001;
    slave_bus_in <= v;
    repeat (2) @(posedge pclk);
    third_port_in <= 3'b111;
    repeat (2) @(posedge pclk);
    slave_bus_in <= ~v;
  endtask
  // Strobed read of the output word
  task ext_rd(output byte_t v, output logic oe);
    @(posedge pclk);
    third_port_in <= 3'b010;
    repeat (3) @(posedge pclk);
    v = slave_bus_out;
    oe = slave_bus_oe;
    third_port_in <= 3'b111;
    repeat (2) @(posedge pclk);
  endtask
endmodule

// >>> tb/multi_port_gpio_test.sv
`timescale 1ns/1ps
module multi_port_gpio_test;
  import gpio_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, prog_mode, pready, pslverr;
  logic change_flag, slave_bus_oe, ext_interrupt_edge, third_port_schmitt;
  logic prog_clock_pin, prog_data_pin;
  logic [31:0] paddr, pwdata, prdata;
  logic [3:0] pstrb;
  logic o;
  byte_t first_port_in, first_port_out, first_port_oe, first_port_pullup;
  byte_t first_port_schmitt, second_port_in, second_port_out;
  byte_t second_port_oe, periph_select, periph_force_out, periph_out;
  byte_t periph_in, slave_bus_in, slave_bus_out, d, v, e, r, x;
  trio_t third_port_in, third_port_out, third_port_oe;
  logic [33:0] note, q[$];
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  integer seed = 32'hde08;
  multi_port_gpio multi_port_gpio_inst (.pclk, .presetn, .clk_en(1'b1),
    .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .first_port_in, .first_port_out, .first_port_oe,
    .first_port_pullup, .first_port_schmitt, .prog_mode,
    .ext_interrupt_edge, .change_flag, .prog_clock_pin, .prog_data_pin,
    .second_port_in, .second_port_out, .second_port_oe, .periph_select,
    .periph_force_out, .periph_out, .periph_in, .third_port_in,
    .third_port_out, .third_port_oe, .third_port_schmitt, .slave_bus_in,
    .slave_bus_out, .slave_bus_oe);
  pin_model pin_model_inst (.pclk, .first_port_out, .first_port_oe,
    .first_port_pullup, .first_port_in, .third_port_in, .slave_bus_in,
    .slave_bus_out, .slave_bus_oe);
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task chk(input logic [31:0] s, input logic [31:0] t);
    n_compared++;
    if (s !== t) begin
      error_cnt++;
      $display("FAIL t=%0t seen %h exp %h", $time, s, t);
    end
  endtask
  task stop_test;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // One transfer; the answer is noted for the scoreboard
  task apb(input logic w, input logic [7:0] a, input byte_t t,
    input logic err);
    q.push_back({~w, err, 24'h0, t});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {22'h0, a, 2'b00};
    pwdata <= {24'h0, t};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Scoreboard and hang guard
  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      note = q.pop_front();
      chk({31'h0, pslverr}, {31'h0, note[32]});
      if (note[33]) chk(prdata, note[31:0]);
    end
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      stop_test();
    end
  end
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, prog_mode} = 4'h0;
    pstrb = 4'hf;
    {paddr, pwdata} = 64'h0;
    {periph_select, periph_force_out, periph_out, second_port_in} = 32'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 8'h81, 8'hff, 0);
    apb(0, 8'h86, 8'hff, 0);
    apb(0, 8'h89, 8'h07, 0);
    chk(first_port_oe, 0);
    chk(ext_interrupt_edge, 1);
    pstrb <= 4'h0;
    apb(1, 8'h81, 8'h00, 0);
    pstrb <= 4'hf;
    apb(0, 8'h81, 8'hff, 0);
    apb(0, 8'h40, 8'h00, 1);
    apb(1, 8'h40, 8'h00, 1);
    apb(1, 8'h89, 8'hca, 0);
    apb(1, 8'h09, 8'h05, 0);
    apb(0, 8'h89, 8'h02, 0);
    chk(third_port_oe, 3'h5);
    chk(third_port_out, 3'h5);
    $display("test reset done");
    repeat (6) begin
      {d, v, e, r} = $random(seed);
      periph_select <= r;
      periph_force_out <= v;
      periph_out <= e;
      second_port_in <= v;
      prog_mode <= r[0];
      pin_model_inst.drive(e, 8'hff);
      apb(1, 8'h86, d, 0);
      apb(1, 8'h06, v, 0);
      apb(1, 8'h87, d, 0);
      apb(1, 8'h07, v, 0);
      apb(1, 8'h81, {r[7], r[6], 6'h3f}, 0);
      apb(0, 8'h06, (v & ~d) | (e & d), 0);
      chk(first_port_oe, d ^ 8'hff);
      chk(first_port_out, v);
      chk(first_port_pullup, r[7] ? 8'h00 : d);
      chk(second_port_oe, (r & v) | ((r | d) ^ 8'hff));
      chk(second_port_out, (r & e) | (v & ~r));
      chk(periph_in, v);
      chk(ext_interrupt_edge, r[6]);
    end
    $display("test random done");
    apb(1, 8'h86, 8'hff, 0);
    apb(1, 8'h81, 8'h7f, 0);
    pin_model_inst.drive(e, 8'h0f);
    apb(0, 8'h06, {4'hf, e[3:0]}, 0);
    apb(1, 8'h0b, 8'h01, 0);
    repeat (2) @(posedge pclk);
    chk(change_flag, 0);
    pin_model_inst.drive({4'hd, e[3:0]}, 8'hff);
    repeat (3) @(posedge pclk);
    chk(change_flag, 1);
    apb(0, 8'h06, {4'hd, e[3:0]}, 0);
    apb(1, 8'h0b, 8'h01, 0);
    apb(0, 8'h0b, 8'h00, 0);
    $display("test change done");
    apb(1, 8'h89, 8'h17, 0);
    repeat (2) @(posedge pclk);
    chk(third_port_schmitt, 0);
    pin_model_inst.ext_wr(v);
    apb(0, 8'h89, 8'h97, 0);
    apb(0, 8'h08, v, 0);
    apb(0, 8'h89, 8'h17, 0);
    pin_model_inst.ext_wr(d);
    pin_model_inst.ext_wr(d);
    apb(0, 8'h89, 8'hb7, 0);
    apb(1, 8'h89, 8'h17, 0);
    apb(0, 8'h89, 8'h97, 0);
    apb(0, 8'h08, d, 0);
    apb(1, 8'h08, e, 0);
    apb(0, 8'h89, 8'h57, 0);
    pin_model_inst.ext_rd(x, o);
    chk(x, e);
    chk(o, 1);
    apb(0, 8'h89, 8'h17, 0);
    apb(1, 8'h89, 8'h07, 0);
    repeat (2) @(posedge pclk);
    chk(third_port_schmitt, 1);
    $display("test slave done");
    stop_test();
  end
endmodule
bind multi_port_gpio gpio_port_chk gpio_port_chk_inst (.pclk, .presetn,
  .psel, .penable, .pready, .pslverr, .prdata, .prog_mode,
  .prog_clock_pin, .prog_data_pin, .first_port_in, .first_port_oe,
  .first_port_pullup, .first_port_schmitt, .second_port_oe,
  .periph_select, .periph_force_out);
